//--- rtl/sebs_defines.svh
`ifndef SEBS_DEFINES_SVH
`define SEBS_DEFINES_SVH

// ************************************************
// address fields
// ************************************************
`define SEBS_TYPE_MEM        4'hA
`define SEBS_TYPE_LOCK       4'h6
`define SEBS_BIT_RW          0
`define SEBS_MEM_BYTES       256
`define SEBS_PAGE_BYTES      16
`define SEBS_PROT_LIMIT      8'h80

// ************************************************
// timing
// ************************************************
`define SEBS_CLK_NS          40
`define SEBS_GLITCH_STD_NS   100
`define SEBS_GLITCH_FAST_NS  50
`define SEBS_GLITCH_STD_CYC  ((`SEBS_GLITCH_STD_NS + `SEBS_CLK_NS - 1) / `SEBS_CLK_NS)
`define SEBS_GLITCH_FAST_CYC ((`SEBS_GLITCH_FAST_NS + `SEBS_CLK_NS - 1) / `SEBS_CLK_NS)
`define SEBS_PROG_STD_MS     10
`define SEBS_PROG_LOW_MS     15
`define SEBS_PROG_STD_CYC    ((`SEBS_PROG_STD_MS * 1000000) / `SEBS_CLK_NS)
`define SEBS_PROG_LOW_CYC    ((`SEBS_PROG_LOW_MS * 1000000) / `SEBS_CLK_NS)
`define SEBS_SCL_STD_NS      10000
`define SEBS_SCL_QTR_CYC     (`SEBS_SCL_STD_NS / (4 * `SEBS_CLK_NS))

`endif

//--- rtl/sebs_pkg.sv
package sebs_pkg;

	// device protocol states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_SLAVE = 3'h1,
		ST_WORD  = 3'h2,
		ST_DATA  = 3'h3,
		ST_READ  = 3'h4,
		ST_WAIT  = 3'h5
	} sebs_dev_state_t;

	// master sequencer states
	typedef enum logic [2:0] {
		M_IDLE   = 3'h0,
		M_START  = 3'h1,
		M_BYTE   = 3'h2,
		M_RSTART = 3'h3,
		M_STOP   = 3'h4
	} sebs_mst_state_t;

endpackage

//--- rtl/sebs_if.sv
`timescale 1ns/1ns
interface sebs_if;
	logic scl_line;
	logic sda_line;
	logic mst_scl_o;
	logic mst_scl_oe;
	logic mst_sda_o;
	logic mst_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;

	// pulled-up wired-and lines
	assign scl_line = ~(mst_scl_oe & ~mst_scl_o);
	assign sda_line = ~((mst_sda_oe & ~mst_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport dev (input scl_line, input sda_line, output dev_sda_o, output dev_sda_oe);
	modport mst (input scl_line, input sda_line, output mst_scl_o, output mst_scl_oe,
		output mst_sda_o, output mst_sda_oe);
endinterface

//--- rtl/sebs_device.sv
`timescale 1ns/1ns
`include "sebs_defines.svh"
module sebs_device #(
	parameter int unsigned PROG_CYCLES = `SEBS_PROG_STD_CYC,
	parameter int unsigned GLITCH_CYC  = `SEBS_GLITCH_STD_CYC
) (
	// system
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// strapped device address
	input  wire logic [2:0] chip_select_straps,
	// status
	output logic            busy,
	output logic            wp_locked,
	// two-wire bus
	sebs_if.dev             bus
);
	localparam int CW = $clog2(PROG_CYCLES + 1);
	localparam int GW = $clog2(GLITCH_CYC + 1);

	// ************************************************
	// input synchronisers and glitch filters
	// ************************************************
	logic [1:0] raw;
	logic [1:0] clean;
	logic [2:0] strap_s1_q;
	logic [2:0] strap_s2_q;

	assign raw = {bus.scl_line, bus.sda_line};

	// per-line filter
	// a change must persist GLITCH_CYC samples before it is believed
	genvar g;
	for (g = 0; g < 2; g++) begin : g_line
		logic          s1_q;
		logic          s2_q;
		logic          flt_q;
		logic [GW-1:0] cnt_q;

		// two flops before anything looks at the pin
		always_ff @(posedge clock) begin
			if (sys_rst) begin
				s1_q <= 1'h1;
				s2_q <= 1'h1;
			end else begin
				s1_q <= raw[g];
				s2_q <= s1_q;
			end
		end

		// short pulses never reach flt_q
		always_ff @(posedge clock) begin
			if (sys_rst) begin
				flt_q <= 1'h1;
				cnt_q <= '0;
			end else if (s2_q == flt_q) begin
				cnt_q <= '0;
			end else if (cnt_q == GW'(GLITCH_CYC - 1)) begin
				flt_q <= s2_q;
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + GW'(1);
			end
		end

		assign clean[g] = flt_q;
	end

	// straps are static pins but still cross domains
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			strap_s1_q <= 3'h0;
			strap_s2_q <= 3'h0;
		end else begin
			strap_s1_q <= chip_select_straps;
			strap_s2_q <= strap_s1_q;
		end
	end

	// ************************************************
	// bus events
	// ************************************************
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// previous filtered levels
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end else begin
			scl_q <= clean[1];
			sda_q <= clean[0];
		end
	end

	// bits move on serial clock edges
	assign scl_rise  = clean[1] & ~scl_q;
	assign scl_fall  = ~clean[1] & scl_q;
	assign start_det = scl_q & clean[1] & sda_q & ~clean[0];
	assign stop_det  = scl_q & clean[1] & ~sda_q & clean[0];

	// ************************************************
	// protocol engine
	// ************************************************
	sebs_pkg::sebs_dev_state_t state_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [7:0] addr_q;
	logic       ack_q;
	logic       rd_q;
	logic       lock_mode_q;
	logic       mack_q;
	logic       sda_oe_q;
	logic       wr_pend_q;
	logic       busy_q;
	logic       wp_locked_q;
	logic [7:0] mem_q [`SEBS_MEM_BYTES];

	logic       byte_end;
	logic       ack_end;
	logic       slave_hit;
	logic       type_mem;
	logic       type_lock;
	logic       ack_now;
	logic       mem_we;
	logic [7:0] rd_byte;

	assign byte_end = scl_fall && (cnt_q == 4'h7);
	assign ack_end  = scl_fall && (cnt_q == 4'h8);
	assign slave_hit = shift_q[3:1] == strap_s2_q;
	assign type_mem  = shift_q[7:4] == `SEBS_TYPE_MEM;
	// lock register only by write, only while unlocked
	assign type_lock = (shift_q[7:4] == `SEBS_TYPE_LOCK) && !wp_locked_q && !shift_q[`SEBS_BIT_RW];
	assign rd_byte   = mem_q[addr_q];

	// acknowledge decision at the end of a received byte
	always_comb begin
		ack_now = 1'h0;
		case (state_q)
			sebs_pkg::ST_SLAVE: ack_now = !busy_q && slave_hit && (type_mem || type_lock);
			sebs_pkg::ST_WORD:  ack_now = 1'h1;
			sebs_pkg::ST_DATA:  ack_now = 1'h1;
			default:            ack_now = 1'h0;
		endcase
	end

	// low half of the array is barred once locked
	assign mem_we = byte_end && (state_q == sebs_pkg::ST_DATA) && !lock_mode_q
		&& !(wp_locked_q && (addr_q < `SEBS_PROT_LIMIT));

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q     <= sebs_pkg::ST_IDLE;
			cnt_q       <= 4'h0;
			shift_q     <= 8'h00;
			tx_q        <= 8'h00;
			addr_q      <= 8'h00;
			ack_q       <= 1'h0;
			rd_q        <= 1'h0;
			lock_mode_q <= 1'h0;
			mack_q      <= 1'h0;
			sda_oe_q    <= 1'h0;
			wr_pend_q   <= 1'h0;
		end else if (start_det) begin
			state_q  <= sebs_pkg::ST_SLAVE;
			cnt_q    <= 4'hF; // the start's own clock fall wraps this to zero, so it is not counted as a bit
			sda_oe_q <= 1'h0;
		end else if (stop_det) begin
			// pending data is handed to the program timer here
			state_q   <= sebs_pkg::ST_IDLE;
			cnt_q     <= 4'h0;
			sda_oe_q  <= 1'h0;
			wr_pend_q <= 1'h0;
		end else begin
			case (state_q)
				sebs_pkg::ST_SLAVE, sebs_pkg::ST_WORD, sebs_pkg::ST_DATA: begin
					if (scl_rise && (cnt_q < 4'h8)) begin
						shift_q <= {shift_q[6:0], clean[0]};
					end
					if (byte_end) begin
						cnt_q <= 4'h8;
						// pull low through the ninth clock
						sda_oe_q <= ack_now;
						ack_q    <= ack_now;
						if (state_q == sebs_pkg::ST_SLAVE) begin
							rd_q        <= shift_q[`SEBS_BIT_RW];
							lock_mode_q <= !type_mem;
						end else if (state_q == sebs_pkg::ST_WORD) begin
							// all eight bits address one block
							if (!lock_mode_q) begin
								addr_q <= shift_q;
							end
						end else begin
							// roll over inside the 16-byte page
							addr_q <= {addr_q[7:4], addr_q[3:0] + 4'h1};
							if (mem_we || lock_mode_q) begin
								wr_pend_q <= 1'h1;
							end
						end
					end else if (ack_end) begin
						cnt_q    <= 4'h0;
						sda_oe_q <= 1'h0;
						if (state_q == sebs_pkg::ST_SLAVE) begin
							if (!ack_q) begin
								state_q <= sebs_pkg::ST_WAIT;
							end else if (rd_q) begin
								state_q  <= sebs_pkg::ST_READ;
								tx_q     <= rd_byte;
								sda_oe_q <= ~rd_byte[7];
								addr_q   <= addr_q + 8'h01;
							end else begin
								state_q <= sebs_pkg::ST_WORD;
							end
						end else begin
							state_q <= sebs_pkg::ST_DATA;
						end
					end else if (scl_fall) begin
						cnt_q <= cnt_q + 4'h1;
					end
				end
				sebs_pkg::ST_READ: begin
					// master answer sampled on the ninth rise
					if (scl_rise && (cnt_q == 4'h8)) begin
						mack_q <= ~clean[0];
					end
					if (scl_fall) begin
						if (cnt_q < 4'h7) begin
							cnt_q <= cnt_q + 4'h1;
							tx_q  <= {tx_q[6:0], 1'h0};
							// a one is sent by letting go
							sda_oe_q <= ~tx_q[6];
						end else if (cnt_q == 4'h7) begin
							cnt_q    <= 4'h8;
							sda_oe_q <= 1'h0;
						end else if (mack_q) begin
							cnt_q    <= 4'h0;
							tx_q     <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
							addr_q   <= addr_q + 8'h01;
						end else begin
							state_q <= sebs_pkg::ST_WAIT;
						end
					end
				end
				default: begin
					cnt_q <= 4'h0;
				end
			endcase
		end
	end

	// array write, no reset: contents are the stored data
	always_ff @(posedge clock) begin
		if (mem_we) begin
			mem_q[addr_q] <= shift_q;
		end
	end

	// ************************************************
	// program cycle timer and lock
	// ************************************************
	logic [CW-1:0] prog_cnt_q;

	// counter holds busy until it expires
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			busy_q     <= 1'h0;
			prog_cnt_q <= '0;
		end else if (stop_det && wr_pend_q && !busy_q) begin
			busy_q     <= 1'h1;
			prog_cnt_q <= CW'(PROG_CYCLES - 1);
		end else if (busy_q) begin
			if (prog_cnt_q == '0) begin
				busy_q <= 1'h0;
			end else begin
				prog_cnt_q <= prog_cnt_q - CW'(1);
			end
		end
	end

	// one-time lock, taken at the closing stop
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wp_locked_q <= 1'h0;
		end else if (stop_det && wr_pend_q && lock_mode_q) begin
			wp_locked_q <= 1'h1;
		end
	end

	assign bus.dev_sda_o  = 1'h0;
	assign bus.dev_sda_oe = sda_oe_q;
	assign busy           = busy_q;
	assign wp_locked      = wp_locked_q;
endmodule

//--- rtl/sebs_master.sv
`timescale 1ns/1ns
`include "sebs_defines.svh"
module sebs_master #(
	parameter int unsigned QUARTER = `SEBS_SCL_QTR_CYC
) (
	// system
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// request
	input  wire logic       req,
	input  wire logic       rw,
	input  wire logic [3:0] dev_type,
	input  wire logic [2:0] dev_sel,
	input  wire logic [7:0] word_addr,
	input  wire logic [7:0] wdata,
	// answer
	output logic            ready,
	output logic            done,
	output logic            nack,
	output logic [7:0]      rdata,
	// two-wire bus
	sebs_if.mst             bus
);
	localparam int QW = $clog2(QUARTER + 1);

	sebs_pkg::sebs_mst_state_t state_q;
	logic [QW-1:0] qcnt_q;
	logic [1:0]    ph_q;
	logic [3:0]    bit_q;
	logic [1:0]    idx_q;
	logic          rw_q;
	logic [3:0]    type_q;
	logic [2:0]    sel_q;
	logic [7:0]    word_q;
	logic [7:0]    wdata_q;
	logic [7:0]    rx_q;
	logic          ack_q;
	logic          scl_oe_q;
	logic          sda_oe_q;
	logic          done_q;
	logic          nack_q;
	logic [7:0]    rdata_q;
	logic          s1_q;
	logic          s2_q;
	logic          tick;
	logic [7:0]    tx_cur;
	logic          rd_byte;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s1_q <= 1'h1;
			s2_q <= 1'h1;
		end else begin
			s1_q <= bus.sda_line;
			s2_q <= s1_q;
		end
	end

	// quarter-period divider makes the serial clock
	always_ff @(posedge clock) begin
		if (sys_rst || state_q == sebs_pkg::M_IDLE) begin
			qcnt_q <= '0;
		end else if (tick) begin
			qcnt_q <= '0;
		end else begin
			qcnt_q <= qcnt_q + QW'(1);
		end
	end
	assign tick = qcnt_q == QW'(QUARTER - 1);

	// byte sequence: address, word, then data or readback address
	always_comb begin
		case (idx_q)
			2'h0:    tx_cur = {type_q, sel_q, 1'h0};
			2'h1:    tx_cur = word_q;
			2'h2:    tx_cur = rw_q ? {type_q, sel_q, 1'h1} : wdata_q;
			default: tx_cur = 8'hFF;
		endcase
	end
	// readback byte follows the read address
	assign rd_byte = rw_q && (idx_q == 2'h3);

	// sequencer: four quarter phases per bit
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q  <= sebs_pkg::M_IDLE;
			ph_q     <= 2'h0;
			bit_q    <= 4'h0;
			idx_q    <= 2'h0;
			rw_q     <= 1'h0;
			type_q   <= 4'h0;
			sel_q    <= 3'h0;
			word_q   <= 8'h00;
			wdata_q  <= 8'h00;
			rx_q     <= 8'h00;
			ack_q    <= 1'h0;
			scl_oe_q <= 1'h0;
			sda_oe_q <= 1'h0;
			done_q   <= 1'h0;
			nack_q   <= 1'h0;
			rdata_q  <= 8'h00;
		end else begin
			done_q <= 1'h0;
			if (state_q == sebs_pkg::M_IDLE) begin
				if (req) begin
					state_q <= sebs_pkg::M_START;
					ph_q    <= 2'h0;
					rw_q    <= rw;
					type_q  <= dev_type;
					sel_q   <= dev_sel;
					word_q  <= word_addr;
					wdata_q <= wdata;
					nack_q  <= 1'h0;
				end
			end else if (tick) begin
				ph_q <= ph_q + 2'h1;
				case (state_q)
					// start: data falls while clock high
					sebs_pkg::M_START: begin
						if (ph_q == 2'h1) begin
							sda_oe_q <= 1'h1;
						end else if (ph_q == 2'h2) begin
							scl_oe_q <= 1'h1;
							state_q  <= sebs_pkg::M_BYTE;
							ph_q     <= 2'h0;
							bit_q    <= 4'h0;
							idx_q    <= 2'h0;
						end
					end
					sebs_pkg::M_BYTE: begin
						case (ph_q)
							2'h0: sda_oe_q <= (bit_q < 4'h8) && !rd_byte && !tx_cur[3'h7 - bit_q[2:0]];
							2'h1: scl_oe_q <= 1'h0;
							2'h2: begin
								if (bit_q < 4'h8) begin
									rx_q <= {rx_q[6:0], s2_q};
								end else begin
									ack_q <= ~s2_q;
								end
							end
							default: begin
								scl_oe_q <= 1'h1;
								if (bit_q < 4'h8) begin
									bit_q <= bit_q + 4'h1;
								end else begin
									bit_q <= 4'h0;
									// single readback byte ends with no acknowledge
									if (rd_byte) begin
										rdata_q <= rx_q;
										state_q <= sebs_pkg::M_STOP;
									end else if (!ack_q) begin
										nack_q  <= 1'h1;
										state_q <= sebs_pkg::M_STOP;
									end else if (!rw_q && idx_q == 2'h2) begin
										state_q <= sebs_pkg::M_STOP;
									end else if (rw_q && idx_q == 2'h1) begin
										state_q <= sebs_pkg::M_RSTART;
										idx_q   <= 2'h2;
									end else begin
										idx_q <= idx_q + 2'h1;
									end
								end
							end
						endcase
					end
					sebs_pkg::M_RSTART: begin
						case (ph_q)
							2'h0:    sda_oe_q <= 1'h0;
							2'h1:    scl_oe_q <= 1'h0;
							2'h2:    sda_oe_q <= 1'h1;
							default: begin
								scl_oe_q <= 1'h1;
								state_q  <= sebs_pkg::M_BYTE;
							end
						endcase
					end
					// stop: data rises while clock high
					sebs_pkg::M_STOP: begin
						case (ph_q)
							2'h0:    sda_oe_q <= 1'h1;
							2'h1:    scl_oe_q <= 1'h0;
							2'h2:    sda_oe_q <= 1'h0;
							default: begin
								state_q <= sebs_pkg::M_IDLE;
								done_q  <= 1'h1;
							end
						endcase
					end
					default: state_q <= sebs_pkg::M_IDLE;
				endcase
			end
		end
	end

	// open-drain style outputs
	assign bus.mst_scl_o  = 1'h0;
	assign bus.mst_scl_oe = scl_oe_q;
	assign bus.mst_sda_o  = 1'h0;
	assign bus.mst_sda_oe = sda_oe_q;
	assign ready          = state_q == sebs_pkg::M_IDLE;
	assign done           = done_q;
	assign nack           = nack_q;
	assign rdata          = rdata_q;
endmodule

//--- tb/sebs_chk.sv
`timescale 1ns/1ns
// ************************************************
// wire checks on the joined two-wire link
// ************************************************
module sebs_chk #(
	parameter int unsigned PROG_CYCLES = 400
) (
	// system
	input wire logic clock,
	input wire logic sys_rst,
	// device status
	input wire logic busy,
	// link lines and drivers
	input wire logic scl_line,
	input wire logic sda_line,
	input wire logic mst_scl_o,
	input wire logic mst_scl_oe,
	input wire logic mst_sda_o,
	input wire logic mst_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe
);
	logic [19:0] busy_cnt_q;
	logic [4:0]  stop_age_q;
	logic        scl_q;
	logic        sda_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// length of the running program cycle
	always_ff @(posedge clock) begin
		if (sys_rst || !busy)
			busy_cnt_q <= 20'h00000;
		else
			busy_cnt_q <= busy_cnt_q + 20'h00001;
	end

	// previous line levels for raw stop detection
	always_ff @(posedge clock) begin
		scl_q <= scl_line;
		sda_q <= sda_line;
	end

	// cycles since a raw stop; saturates so a stale stop never excuses a late busy
	always_ff @(posedge clock) begin
		if (sys_rst)
			stop_age_q <= 5'h1F;
		else if (scl_q && scl_line && !sda_q && sda_line)
			stop_age_q <= 5'h00;
		else if (stop_age_q != 5'h1F)
			stop_age_q <= stop_age_q + 5'h01;
	end

	property p_dev_low; dev_sda_oe |-> !dev_sda_o; endproperty
	a_dev_low: assert property (p_dev_low) else $error("device drove data high");
	property p_mst_low; !(mst_sda_oe && mst_sda_o) && !(mst_scl_oe && mst_scl_o); endproperty
	a_mst_low: assert property (p_mst_low) else $error("master drove a line high");
	property p_busy_quiet; busy |-> !dev_sda_oe; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("data driven while programming");
	property p_busy_len; busy_cnt_q <= PROG_CYCLES + 1; endproperty
	a_busy_len: assert property (p_busy_len) else $error("program cycle too long");
	property p_busy_cause; $rose(busy) |-> stop_age_q <= 5'h0C; endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("program cycle without stop");
	property p_busy_idle; $rose(busy) |-> scl_line && sda_line; endproperty
	a_busy_idle: assert property (p_busy_idle) else $error("program cycle on a busy link");
	property p_busy_hold; $rose(busy) |=> busy [*8]; endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
	property p_dev_edge; $changed(dev_sda_oe) |-> !scl_line; endproperty
	a_dev_edge: assert property (p_dev_edge) else $error("data changed while clock high");
endmodule

//--- tb/sebs_tb.sv
`timescale 1ns/1ns
module sebs_tb;
	localparam int unsigned QUARTER = 8;
	localparam int unsigned PROG = 400;
	localparam logic [7:0] CORNER [5] = '{8'h00, 8'hFF, 8'h7F, 8'h80, 8'h10};
	localparam logic [3:0] BADTYPE [5] = '{4'h0, 4'hB, 4'h2, 4'h5, 4'h6};
	logic       clock, sys_rst, req, rw, ready, done, nack, busy, wp_locked, ack_g, locked_m;
	logic [3:0] dev_type;
	logic [2:0] dev_sel, straps;
	logic [7:0] word_addr, wdata, rdata;
	logic [7:0] mem_m [256];
	int         n_errors, n_checks, seed, cycles;

	sebs_if i_sebs_if ();
	sebs_if i_sebs_if_g ();
	sebs_master #(.QUARTER(QUARTER)) i_sebs_master (.clock, .sys_rst, .req, .rw, .dev_type, .dev_sel,
		.word_addr, .wdata, .ready, .done, .nack, .rdata, .bus(i_sebs_if.mst));
	// one 2-Kbit device per link, well under the bus limit
	sebs_device #(.PROG_CYCLES(PROG)) i_sebs_device (.clock, .sys_rst, .chip_select_straps(straps),
		.busy, .wp_locked, .bus(i_sebs_if.dev));
	// second device on a link that the bench bit-bangs, for line faults
	sebs_device #(.PROG_CYCLES(PROG)) i_sebs_device_g (.clock, .sys_rst, .chip_select_straps(3'h5),
		.busy(), .wp_locked(), .bus(i_sebs_if_g.dev));
	sebs_chk #(.PROG_CYCLES(PROG)) i_sebs_chk (.clock, .sys_rst, .busy, .scl_line(i_sebs_if.scl_line),
		.sda_line(i_sebs_if.sda_line), .mst_scl_o(i_sebs_if.mst_scl_o), .mst_scl_oe(i_sebs_if.mst_scl_oe),
		.mst_sda_o(i_sebs_if.mst_sda_o), .mst_sda_oe(i_sebs_if.mst_sda_oe),
		.dev_sda_o(i_sebs_if.dev_sda_o), .dev_sda_oe(i_sebs_if.dev_sda_oe));

	// ************************************************
	// clock, watchdog and reporting
	// ************************************************
	always #20 clock = ~clock;

	// hang guard, sized well above the expected run
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			n_errors++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t byte %h expected %h", $time, got, exp);
		end
	endtask

	// ************************************************
	// expectations and bus tasks
	// ************************************************
	function automatic logic exp_nack(input logic r, input logic [3:0] t, input logic [2:0] s);
		if (s != straps)
			return 1'b1;
		if (t == 4'hA)
			return 1'b0;
		return !(t == 4'h6 && !r && !locked_m);
	endfunction

	// one master request; fields held until the taking edge, then wait for done
	task automatic xfer(input logic r, input logic [3:0] t, input logic [2:0] s, input logic [7:0] a,
		input logic [7:0] d);
		int k;
		@(posedge clock);
		req <= 1'b1;
		rw <= r;
		dev_type <= t;
		dev_sel <= s;
		word_addr <= a;
		wdata <= d;
		@(posedge clock);
		req <= 1'b0;
		k = 0;
		do begin
			@(posedge clock);
			#1;
			k++;
		end while (done !== 1'b1 && k < 4000);
		chk_bit(done, 1'b1);
	endtask

	// bounded wait for the program cycle to end
	task automatic wait_idle;
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 1000) begin
			@(posedge clock);
			#1;
			k++;
		end
		chk_bit(busy, 1'b0);
	endtask

	// write, poll while programming, then read back
	task automatic wr_poll(input logic [7:0] a, input logic [7:0] d);
		logic st;
		st = !(locked_m && a < 8'h80);
		xfer(1'b0, 4'hA, straps, a, d);
		chk_bit(nack, 1'b0);
		chk_bit(busy, st);
		if (st)
			mem_m[a] = d;
		xfer(1'b1, 4'hA, straps, a, 8'h00);
		chk_bit(nack, st);
		wait_idle();
		xfer(1'b1, 4'hA, straps, a, 8'h00);
		chk_bit(nack, 1'b0);
		chk_byte(rdata, mem_m[a]);
	endtask

	// one bit-bang step on the second link: levels held for n cycles
	task automatic bb(input logic c, input logic d, input int n);
		i_sebs_if_g.mst_scl_oe <= ~c;
		i_sebs_if_g.mst_sda_oe <= ~d;
		repeat (n) @(posedge clock);
	endtask

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		seed = 74733;
		clock = 1'b0;
		sys_rst = 1'b1;
		{req, rw, dev_type, dev_sel, word_addr, wdata} = '0;
		{n_errors, n_checks, cycles} = '0;
		locked_m = 1'b0;
		straps = 3'($random(seed));
		i_sebs_if_g.mst_scl_o = 1'b0;
		i_sebs_if_g.mst_sda_o = 1'b0;
		i_sebs_if_g.mst_scl_oe = 1'b0;
		i_sebs_if_g.mst_sda_oe = 1'b0;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		#1;
		chk_bit(busy | wp_locked | done | nack, 1'b0);
		chk_bit(ready & i_sebs_if.scl_line & i_sebs_if.sda_line, 1'b1);
		chk_byte(rdata, 8'h00);
		// corner addresses first, then random ones
		for (int i = 0; i < 8; i++)
			wr_poll((i < 5) ? CORNER[i] : 8'($random(seed)), 8'($random(seed)));
		// every strap value, only the strapped one answers
		for (int s = 0; s < 8; s++) begin
			xfer(1'b1, 4'hA, 3'(s), 8'h00, 8'h00);
			chk_bit(nack, exp_nack(1'b1, 4'hA, 3'(s)));
		end
		chk_byte(rdata, mem_m[0]);
		// foreign type fields and a read of the lock register are refused
		for (int i = 0; i < 5; i++) begin
			xfer(1'b1, BADTYPE[i], straps, 8'h00, 8'h00);
			chk_bit(nack, exp_nack(1'b1, BADTYPE[i], straps));
		end
		// lock write reaches the lock register only
		xfer(1'b0, 4'h6, straps, 8'h10, 8'($random(seed)));
		chk_bit(nack, 1'b0);
		chk_bit(busy, 1'b1);
		wait_idle();
		chk_bit(wp_locked, 1'b1);
		locked_m = 1'b1;
		xfer(1'b1, 4'hA, straps, 8'h10, 8'h00);
		chk_byte(rdata, mem_m[8'h10]);
		wr_poll(8'h10, ~mem_m[8'h10]);
		wr_poll(8'h90, 8'($random(seed)));
		xfer(1'b0, 4'h6, straps, 8'h10, 8'h00);
		chk_bit(nack, exp_nack(1'b0, 4'h6, straps));
		// second link: address 1010_101_0 with an 80 ns data dip while clock high
		bb(1'b1, 1'b1, 4);
		bb(1'b1, 1'b0, 4);
		bb(1'b0, 1'b0, 1);
		for (int i = 7; i >= 0; i--) begin
			bb(1'b0, i[0] == 1'b0 ? 1'b0 : 1'b1, 3);
			bb(1'b1, i[0] != 1'b0, (i == 5) ? 1 : 4);
			if (i == 5) begin
				bb(1'b1, 1'b0, 2);
				bb(1'b1, 1'b1, 1);
			end
			bb(1'b0, i[0] != 1'b0, 1);
		end
		bb(1'b0, 1'b1, 3);
		bb(1'b1, 1'b1, 4);
		ack_g = i_sebs_if_g.sda_line;
		bb(1'b0, 1'b1, 1);
		bb(1'b0, 1'b0, 4);
		bb(1'b1, 1'b0, 4);
		bb(1'b1, 1'b1, 4);
		chk_bit(ack_g, 1'b0);
		end_sim();
	end
endmodule
